// ===== hw/fcs_fifo_flags.sv
// FIFO core with reset-sampled options, offset registers and status flags
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module fcs_fifo_flags
   import fcs_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEF
) (
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                partial_reset_n_i,
   input  wire logic                wr_tick_i,
   input  wire logic                rd_tick_i,
   input  wire logic                write_en_n_i,
   input  wire logic                read_en_n_i,
   input  wire logic                serial_en_n_i,
   input  wire logic                offset_load_n_i,
   input  wire logic                flag_select_lo_i,
   input  wire logic                flag_select_hi_i,
   input  wire logic                fall_through_serial_in_i,
   input  wire logic                input_width_sel_i,
   input  wire logic                output_width_sel_i,
   input  wire logic                endian_sel_n_i,
   input  wire logic                flag_timing_sel_i,
   input  wire logic                parity_placement_sel_i,
   input  wire logic [WORD_W-1:0]   data_in_i,
   output logic      [WORD_W-1:0]   data_out_o,
   output logic                     full_n_o,
   output logic                     input_ready_n_o,
   output logic                     empty_n_o,
   output logic                     output_ready_n_o,
   output logic                     almost_full_n_o,
   output logic                     almost_empty_n_o,
   output logic                     half_full_n_o
);
   // ************************************************************
   // Sizes and state
   // ************************************************************
   localparam int              AW    = $clog2(2 * DEPTH);
   localparam int              CW    = AW + 1;
   localparam logic [CW-1:0]   CAP_B = CW'(2 * DEPTH);

   fcs_cfg_t              cfg;
   logic [BYTE_W-1:0]     mem [2 * DEPTH];
   logic [AW-1:0]         wptr;
   logic [AW-1:0]         rptr;
   logic [CW-1:0]         cnt;
   logic [AW-1:0]         empty_off;
   logic [AW-1:0]         full_off;
   fcs_ofs_t              ld_ph;
   fcs_ofs_t              rb_ph;
   logic                  out_valid;
   logic [2:0]            e_pipe;
   logic [1:0]            f_pipe;
   logic                  clr;

   assign clr = !reset_n_i || !partial_reset_n_i;

   function automatic logic [CW-1:0] to_units(input logic [CW-1:0] b, input logic wide);
      to_units = wide ? (b >> 1) : b;
   endfunction : to_units

   function automatic logic [CW-1:0] nbytes(input logic wide);
      nbytes = wide ? CW'(BYTES_TWO) : CW'(BYTES_ONE);
   endfunction : nbytes

   // ************************************************************
   // Options latched during master reset
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cfg.fall_through_mode       <= fall_through_serial_in_i;
         cfg.par_load   <= offset_load_n_i;
         cfg.def_sel    <= {offset_load_n_i, flag_select_hi_i, flag_select_lo_i};
         cfg.in_wide    <= input_width_sel_i;
         cfg.out_wide   <= output_width_sel_i;
         cfg.little     <= endian_sel_n_i;
         cfg.sync_flags <= flag_timing_sel_i;
         cfg.ip         <= parity_placement_sel_i;
      end
   end

   // ************************************************************
   // Occupancy and thresholds
   // ************************************************************
   logic [CW-1:0] in_b, out_b, space, occ, cap_u;
   logic          wide, mem_has, wr_go, std_pop, load_out, pop, true_read;
   logic          ae_cond, af_cond, hf_cond;

   assign wide    = cfg.in_wide || cfg.out_wide;
   assign in_b    = nbytes(cfg.in_wide);
   assign out_b   = nbytes(cfg.out_wide);
   assign space   = CAP_B - cnt;
   assign mem_has = cnt >= out_b;
   // Data writes are suppressed while the offset port is in use
   assign wr_go   = wr_tick_i && !write_en_n_i && offset_load_n_i && (space >= in_b);
   assign true_read = rd_tick_i && !read_en_n_i && offset_load_n_i;
   assign std_pop = true_read && e_pipe[1] && mem_has;
   assign load_out = rd_tick_i && offset_load_n_i && e_pipe[2] && mem_has
                     && (!out_valid || !read_en_n_i);
   assign pop     = cfg.fall_through_mode ? load_out : std_pop;

   // Output register counts as storage in fall-through mode
   assign occ   = to_units(cnt + ((cfg.fall_through_mode && out_valid) ? out_b : CW'(0)), wide);
   assign cap_u = to_units(CAP_B, wide);
   assign af_cond = occ >= cap_u + CW'(cfg.fall_through_mode) - CW'(full_off);
   assign ae_cond = occ <= CW'(empty_off) + CW'(cfg.fall_through_mode);
   assign hf_cond = occ > (cap_u >> 1) + CW'(cfg.fall_through_mode);

   // ************************************************************
   // Storage and pointers
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (wr_go) begin
         if (cfg.in_wide) begin
            mem[wptr]          <= cfg.little ? data_in_i[BYTE_W-1:0] : data_in_i[WORD_W-1:BYTE_W];
            mem[AW'(wptr + 1)] <= cfg.little ? data_in_i[WORD_W-1:BYTE_W] : data_in_i[BYTE_W-1:0];
         end else begin
            mem[wptr] <= data_in_i[BYTE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         wptr <= '0;
         rptr <= '0;
         cnt  <= '0;
      end else begin
         if (wr_go) begin
            wptr <= AW'(wptr + in_b);
         end
         if (pop) begin
            rptr <= AW'(rptr + out_b);
         end
         cnt <= cnt + (wr_go ? in_b : CW'(0)) - (pop ? out_b : CW'(0));
      end
   end

   // ************************************************************
   // Read data, offset readback and output-ready
   // ************************************************************
   logic [BYTE_W-1:0] b0, b1;
   logic [VAL_W-1:0]  rb_val;

   assign b0     = mem[rptr];
   assign b1     = mem[AW'(rptr + 1)];
   assign rb_val = VAL_W'((rb_ph == OFS_EMPTY) ? empty_off : full_off);

   always_ff @(posedge clk_i) begin
      if (clr) begin
         data_out_o <= '0;
      end else if (pop) begin
         if (cfg.out_wide) begin
            data_out_o <= cfg.little ? {b1, b0} : {b0, b1};
         end else begin
            data_out_o <= {{(WORD_W-BYTE_W){1'b0}}, b0};
         end
      end else if (rd_tick_i && !read_en_n_i && !offset_load_n_i) begin
         // Parity positions read back as zero
         if (cfg.ip) begin
            data_out_o <= {1'b0, rb_val[15:8], 1'b0, rb_val[7:0]};
         end else begin
            data_out_o <= {2'b00, rb_val};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr || !cfg.fall_through_mode) begin
         out_valid <= 1'b0;
      end else if (load_out) begin
         out_valid <= 1'b1;
      end else if (true_read && out_valid) begin
         out_valid <= 1'b0;
      end
   end

   // ************************************************************
   // Empty and full pipelines
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (clr) begin
         e_pipe <= '0;
      end else if (rd_tick_i) begin
         e_pipe <= {e_pipe[1:0], mem_has};
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         f_pipe <= '1;
      end else if (wr_tick_i) begin
         f_pipe <= {f_pipe[0], (space >= in_b)};
      end
   end

   assign empty_n_o        = cfg.fall_through_mode ? 1'b1 : e_pipe[1];
   assign output_ready_n_o = cfg.fall_through_mode ? !out_valid : 1'b1;
   assign full_n_o         = cfg.fall_through_mode ? 1'b1 : f_pipe[1];
   assign input_ready_n_o  = cfg.fall_through_mode ? !f_pipe[1] : 1'b1;

   // ************************************************************
   // Almost and half flags
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (clr) begin
         almost_empty_n_o <= 1'b0;
      end else if (cfg.sync_flags) begin
         if (rd_tick_i) begin
            almost_empty_n_o <= !ae_cond;
         end
      end else if (rd_tick_i && ae_cond) begin
         almost_empty_n_o <= 1'b0;
      end else if (wr_tick_i && !ae_cond) begin
         almost_empty_n_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         almost_full_n_o <= 1'b1;
      end else if (cfg.sync_flags) begin
         if (wr_tick_i) begin
            almost_full_n_o <= !af_cond;
         end
      end else if (wr_tick_i && af_cond) begin
         almost_full_n_o <= 1'b0;
      end else if (rd_tick_i && !af_cond) begin
         almost_full_n_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         half_full_n_o <= 1'b1;
      end else if (wr_tick_i && hf_cond) begin
         half_full_n_o <= 1'b0;
      end else if (rd_tick_i && !hf_cond) begin
         half_full_n_o <= 1'b1;
      end
   end

   // ************************************************************
   // Offset registers
   // ************************************************************
   logic [VAL_W-1:0] par_val;

   // Interspersed parity drops bits 17 and 8; otherwise bits 16 and 17 are dropped
   assign par_val = cfg.ip ? {data_in_i[16:9], data_in_i[7:0]} : data_in_i[15:0];

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         empty_off <= AW'(OFF_DEF[{offset_load_n_i, flag_select_hi_i, flag_select_lo_i}]);
         full_off  <= AW'(OFF_DEF[{offset_load_n_i, flag_select_hi_i, flag_select_lo_i}]);
         ld_ph     <= OFS_EMPTY;
      end else if (offset_load_n_i) begin
         ld_ph <= OFS_EMPTY;
      end else if (wr_tick_i) begin
         if (!cfg.par_load && !serial_en_n_i) begin
            // Serial chain fills the empty offset LSB first
            {full_off, empty_off} <= {fall_through_serial_in_i, full_off, empty_off[AW-1:1]};
         end else if (cfg.par_load && !write_en_n_i) begin
            unique case (ld_ph)
               OFS_EMPTY: begin
                  empty_off <= AW'(par_val);
                  ld_ph     <= OFS_FULL;
               end
               OFS_FULL: begin
                  full_off <= AW'(par_val);
                  ld_ph    <= OFS_EMPTY;
               end
               default: ld_ph <= OFS_EMPTY;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || offset_load_n_i) begin
         rb_ph <= OFS_EMPTY;
      end else if (rd_tick_i && !read_en_n_i) begin
         rb_ph <= (rb_ph == OFS_EMPTY) ? OFS_FULL : OFS_EMPTY;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_cfg_hold;
      @(posedge clk_i) disable iff (!reset_n_i) $past(reset_n_i) |-> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("option changed outside reset");

   property p_width_sample;
      @(posedge clk_i) disable iff (!reset_n_i)
         $rose(reset_n_i) |-> (cfg.in_wide == $past(input_width_sel_i)) && (cfg.out_wide == $past(output_width_sel_i));
   endproperty
   a_width_sample: assert property (p_width_sample) else $error("width not sampled");

   property p_no_overflow;
      @(posedge clk_i) disable iff (!reset_n_i) cnt <= CAP_B;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("count beyond capacity");

   property p_empty_blocks;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         !cfg.fall_through_mode && !empty_n_o && rd_tick_i && offset_load_n_i |=> $stable(data_out_o) && (cnt >= $past(cnt));
   endproperty
   a_empty_blocks: assert property (p_empty_blocks) else $error("read while empty");

   property p_or_hold;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         cfg.fall_through_mode && !output_ready_n_o && (!rd_tick_i || read_en_n_i) |=> !output_ready_n_o && $stable(data_out_o);
   endproperty
   a_or_hold: assert property (p_or_hold) else $error("output word lost");

   property p_narrow_out;
      @(posedge clk_i) disable iff (!reset_n_i) !cfg.out_wide |-> data_out_o[WORD_W-1:BYTE_W] == '0;
   endproperty
   a_narrow_out: assert property (p_narrow_out) else $error("upper bits driven");

   property p_ae_async;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         !cfg.sync_flags && $past(partial_reset_n_i) && $rose(almost_empty_n_o) |-> $past(wr_tick_i);
   endproperty
   a_ae_async: assert property (p_ae_async) else $error("almost-empty cleared off write edge");

   property p_af_sync;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         cfg.sync_flags && $past(partial_reset_n_i) && $changed(almost_full_n_o) |-> $past(wr_tick_i);
   endproperty
   a_af_sync: assert property (p_af_sync) else $error("almost-full moved off write edge");

   property p_hf_edges;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         $past(partial_reset_n_i) && $changed(half_full_n_o) |->
            (half_full_n_o ? $past(rd_tick_i) : $past(wr_tick_i));
   endproperty
   a_hf_edges: assert property (p_hf_edges) else $error("half-full on wrong edge");

   property p_full_edge;
      @(posedge clk_i) disable iff (!reset_n_i || !partial_reset_n_i)
         $past(partial_reset_n_i) && $changed(f_pipe) |-> $past(wr_tick_i);
   endproperty
   a_full_edge: assert property (p_full_edge) else $error("full moved off write edge");

   c_full: cover property (@(posedge clk_i) disable iff (!reset_n_i) !cfg.fall_through_mode && !full_n_o);
   c_ir: cover property (@(posedge clk_i) disable iff (!reset_n_i) cfg.fall_through_mode && !input_ready_n_o ##1 input_ready_n_o);
   c_readback: cover property (@(posedge clk_i) disable iff (!reset_n_i) !offset_load_n_i && rd_tick_i && !read_en_n_i);
   c_hf: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(half_full_n_o));
endmodule : fcs_fifo_flags

// ===== hw/fcs_pkg.sv
// Package: constants, option bundle and phase codes for the FIFO config/flag block
package fcs_pkg;
   localparam int         DEPTH_DEF  = 8192;      // Word capacity with an 18-bit port
   localparam int         BYTE_W     = 9;
   localparam int         WORD_W     = 18;
   localparam int         PAR_IN_BIT = 8;         // Interspersed parity bit in low byte
   localparam int         VAL_W      = 16;        // Offset value carried on the data port
   localparam logic [1:0] BYTES_ONE  = 2'h1;
   localparam logic [1:0] BYTES_TWO  = 2'h2;
   // Default almost-empty/almost-full offsets, indexed {load, select_hi, select_lo}
   localparam logic [15:0] OFF_DEF [8] = '{16'h0007, 16'h000F, 16'h001F, 16'h003F,
                                           16'h007F, 16'h00FF, 16'h01FF, 16'h03FF};

   typedef struct packed {
      logic fall_through_mode;         // 1: fall-through, 0: standard
      logic par_load;     // 1: parallel offset method, 0: serial
      logic in_wide;      // 1: 18-bit write port
      logic out_wide;     // 1: 18-bit read port
      logic little;       // 1: little-endian
      logic sync_flags;   // 1: synchronous almost flags
      logic ip;           // 1: interspersed parity
      logic [2:0] def_sel;
   } fcs_cfg_t;

   typedef enum logic [1:0] {
      OFS_EMPTY = 2'b01,
      OFS_FULL  = 2'b10
   } fcs_ofs_t;
endpackage : fcs_pkg

// ===== verification/fcs_port_model.sv
// Far-side port clock model: write and read clock edges delivered as tick pulses
`timescale 1ns/100ps
module fcs_port_model (
   input  wire logic clk_i,
   input  wire logic slow_i,
   output logic      wr_tick_o,
   output logic      rd_tick_o
);
   logic [1:0] ph = 2'h0;
   // ****************
   // Port clocks
   // ****************
   // Slow mode stalls both sides; write and read edges then fall on different cycles
   always @(posedge clk_i) begin
      ph        <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      wr_tick_o <= !slow_i || ph == 2'h0;
      rd_tick_o <= !slow_i || ph == 2'h1;
   end
endmodule : fcs_port_model

// ===== verification/fcs_fifo_flags_test.sv
// Self-checking testbench for the FIFO config and status flag block
`timescale 1ns/100ps
module fcs_fifo_flags_test;
   import fcs_pkg::*;
   localparam int DEPTH = 256;
   logic              clk = 1'b0, rst_n = 1'b0, prs_n = 1'b1, slow = 1'b0, ld_n = 1'b1, sel_lo = 1'b0;
   logic              wen_n = 1'b1, ren_n = 1'b1, ow = 1'b1, end_n = 1'b0, flag_timing_sel = 1'b0, tk1 = 1'b0, tk2 = 1'b0;
   logic              wr_tick, rd_tick, full_n, ir_n, ef_n, or_n, af_n, ae_n, hf_n, fts = 1'b0, ip = 1'b0;
   logic [WORD_W-1:0] din = 18'h0_0000, dout, v;
   logic [WORD_W-1:0] exp_q[$];
   int                n_fail = 0, checked = 0, cyc = 0, m = 0;

   always #50 clk = ~clk;

   fcs_fifo_flags #(.DEPTH(DEPTH)) u_fcs_fifo_flags (.clk_i(clk), .reset_n_i(rst_n), .partial_reset_n_i(prs_n),
      .wr_tick_i(wr_tick), .rd_tick_i(rd_tick), .write_en_n_i(wen_n), .read_en_n_i(ren_n), .serial_en_n_i(1'b1),
      .offset_load_n_i(ld_n), .flag_select_lo_i(sel_lo), .flag_select_hi_i(1'b0), .fall_through_serial_in_i(fts),
      .input_width_sel_i(1'b1), .output_width_sel_i(ow), .endian_sel_n_i(end_n), .flag_timing_sel_i(flag_timing_sel),
      .parity_placement_sel_i(ip), .data_in_i(din), .data_out_o(dout), .full_n_o(full_n),
      .input_ready_n_o(ir_n), .empty_n_o(ef_n), .output_ready_n_o(or_n), .almost_full_n_o(af_n),
      .almost_empty_n_o(ae_n), .half_full_n_o(hf_n));
   fcs_port_model u_fcs_port_model (.clk_i(clk), .slow_i(slow), .wr_tick_o(wr_tick), .rd_tick_o(rd_tick));

   task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task test_done;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   // Request held until a port edge takes it, then flags get twelve clock cycles (four port edges in slow mode) to settle
   task xfer(input logic wr, input logic [WORD_W-1:0] d);
      int k;
      k = 0;
      if (wr) begin
         wen_n <= 1'b0;
         din   <= d;
      end else ren_n <= 1'b0;
      do begin
         @(posedge clk);
         k++;
      end while (!(wr ? wr_tick : rd_tick) && k < 20);
      wen_n <= 1'b1;
      ren_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : xfer

   task mreset(input logic wide, input logic e);
      rst_n  <= 1'b0;
      ow     <= wide;
      end_n  <= e;
      sel_lo <= 1'($urandom);
      flag_timing_sel    <= 1'($urandom);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      end_n <= !e; // Pin moves after reset; the latched option must not
      m = int'(OFF_DEF[{2'b10, sel_lo}]);
      repeat (4) @(posedge clk);
   endtask : mreset

   task flags(input int c);
      check(full_n, c < DEPTH, "full_n");
      check(ir_n, 1'b1, "input_ready_n");
      check(ef_n, c > 0, "empty_n");
      check(or_n, 1'b1, "output_ready_n");
      check(af_n, !(c >= DEPTH - m), "almost_full_n");
      check(ae_n, !(c <= m), "almost_empty_n");
      check(hf_n, !(c > DEPTH / 2), "half_full_n");
   endtask : flags

   // ****************
   // Result watcher
   // ****************
   always @(posedge clk) begin
      tk1 <= rd_tick && !ren_n;
      tk2 <= tk1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         test_done();
      end
   end
   always @(negedge clk) if (tk2 && exp_q.size() > 0) check(dout, exp_q.pop_front(), "data_out");

   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(32'h758a_c4bb));
      mreset(1'b1, 1'b0);
      ld_n <= 1'b0;
      repeat (2) begin
         exp_q.push_back({2'b00, OFF_DEF[{2'b10, sel_lo}]});
         xfer(1'b0, 18'h0_0000);
      end
      ld_n <= 1'b1;
      flags(0);
      // One write past capacity must be dropped and never read back
      for (int i = 0; i <= DEPTH; i++) begin
         slow <= 1'($urandom);
         v = WORD_W'($urandom);
         if (i < DEPTH) exp_q.push_back(v);
         xfer(1'b1, v);
         flags(i < DEPTH ? i + 1 : DEPTH);
      end
      for (int i = DEPTH; i > 0; i--) begin
         xfer(1'b0, 18'h0_0000);
         flags(i - 1);
      end
      slow <= 1'b0;
      for (int e = 0; e < 2; e++) begin
         mreset(1'b0, e[0]);
         v = WORD_W'($urandom);
         xfer(1'b1, v);
         exp_q.push_back({9'h000, e[0] ? v[8:0] : v[17:9]});
         xfer(1'b0, 18'h0_0000);
         exp_q.push_back({9'h000, e[0] ? v[17:9] : v[8:0]});
         xfer(1'b0, 18'h0_0000);
      end
      xfer(1'b1, v);
      prs_n <= 1'b0;
      repeat (2) @(posedge clk);
      prs_n <= 1'b1;
      repeat (12) @(posedge clk);
      check(ef_n, 1'b0, "empty_n");
      // Fall-through mode with interspersed parity on readback
      fts <= 1'b1;
      ip  <= 1'b1;
      mreset(1'b1, 1'b0);
      fts  <= 1'b0;
      ld_n <= 1'b0;
      v = {2'b00, OFF_DEF[{2'b10, sel_lo}]};
      exp_q.push_back({1'b0, v[15:8], 1'b0, v[7:0]});
      xfer(1'b0, 18'h0_0000);
      ld_n <= 1'b1;
      check(or_n, 1'b1, "output_ready_n");
      check(ir_n, 1'b0, "input_ready_n");
      v = WORD_W'($urandom);
      xfer(1'b1, v);
      check(or_n, 1'b0, "output_ready_n");
      check(dout, v, "data_out");
      check(full_n, 1'b1, "full_n");
      xfer(1'b0, 18'h0_0000);
      check(or_n, 1'b1, "output_ready_n");
      check(dout, v, "data_out");
      test_done();
   end
endmodule : fcs_fifo_flags_test
